// ==== common/nv_write_pkg.sv ====
// Shared constants for the data EEPROM write controller and its software-side partner.
package nv_write_pkg;

  localparam int unsigned ADDR_W      = 9;
  localparam int unsigned PAGE_W      = 5;
  localparam int unsigned OFS_W       = 4;
  localparam int unsigned PAGE_BYTES  = 16;
  localparam logic [3:0]  OFS_LAST    = 4'hf;

  // Control register bit positions.
  localparam int unsigned CTL_GO_BIT     = 2;
  localparam int unsigned CTL_PERMIT_BIT = 3;
  localparam int unsigned CTL_MODE_BIT   = 4;
  localparam int unsigned CTL_CLRGO_BIT  = 5;
  localparam int unsigned CTL_CLRALW_BIT = 6;
  localparam logic [7:0]  CTL_RESET      = 8'h00;

  // APB offsets of the software-facing registers.
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ADDR   = 8'h08;
  localparam logic [7:0] OFS_DATA   = 8'h0c;

  // Command codes written to OFS_CMD.
  localparam logic [2:0] CMD_BYTE_WRITE = 3'h1;
  localparam logic [2:0] CMD_PAGE_WRITE = 3'h2;
  localparam logic [2:0] CMD_PAGE_ERASE = 3'h3;
  localparam logic [2:0] CMD_SERVICE    = 3'h4;

  // Default cycle length in internal timer ticks.
  localparam int unsigned CYCLE_TICKS = 32;
  localparam int unsigned TICK_DIV    = 4;

endpackage

// ==== common/nv_link_if.sv ====
// Interface joining the EEPROM write controller to its software-side driver.
`timescale 1ns/10ps
`default_nettype none
interface nv_link_if;
  logic       ctl_we;
  logic [7:0] ctl_wdata;
  logic [7:0] ctl_rdata;
  logic       loc_we;
  logic [8:0] loc_wdata;
  logic       byte_we;
  logic [7:0] byte_wdata;
  logic       irq_allow;
  logic       irq_flag;
  logic       irq_service;
  logic [8:0] loc_rdata;

  modport device (
    input  ctl_we, ctl_wdata, loc_we, loc_wdata, byte_we, byte_wdata, irq_allow, irq_service,
    output ctl_rdata, irq_flag, loc_rdata
  );
  modport core (
    output ctl_we, ctl_wdata, loc_we, loc_wdata, byte_we, byte_wdata, irq_allow, irq_service,
    input  ctl_rdata, irq_flag, loc_rdata
  );
endinterface
`default_nettype wire

// ==== hw/nv_write_ctrl.sv ====
// Data EEPROM write controller: control bits, page buffer, timed write and erase cycles.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module nv_write_ctrl #(
  parameter int unsigned CYCLE_LEN = nv_write_pkg::CYCLE_TICKS,
  parameter int unsigned DIV_LEN   = nv_write_pkg::TICK_DIV
) (
  // Clock and reset.
  input  wire logic   clock_i,
  input  wire logic   rst_n_i,
  // Core side.
  nv_link_if.device   link,
  // Array side.
  output logic        array_we_o,
  output logic [8:0]  array_addr_o,
  output logic [7:0]  array_wdata_o,
  output logic        busy_o
);
  import nv_write_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG  = 2'b10,
    ST_DONE  = 2'b11
  } cyc_e;

  cyc_e        state_reg;
  logic [7:0]  ctl_reg;
  logic        permit_prev_reg;
  logic        permit_armed_reg;
  logic        clrallow_armed_reg;
  logic [8:0]  loc_reg;
  logic [7:0]  buf_reg [PAGE_BYTES];
  logic        tag_reg [PAGE_BYTES];
  logic [7:0]  byte_reg;
  logic        irq_reg;
  logic [15:0] tick_div_reg;
  logic        tick_reg;
  logic [15:0] cyc_cnt_reg;
  logic [4:0]  wr_idx_reg;
  logic        busy_reg;
  logic        is_erase_reg;
  logic        page_mode_reg;
  logic        array_we_reg;
  logic [8:0]  array_addr_reg;
  logic [7:0]  array_wdata_reg;

  logic go_write;
  logic go_erase;
  logic cyc_end;
  logic permit_fall;
  logic [7:0] ctl_next;

  // Activation is accepted only when the go (or erase-go) bit arrives in the clock cycle right after the permit (or erase-allow) write.
  assign go_write = link.ctl_we && link.ctl_wdata[CTL_GO_BIT] && ctl_reg[CTL_PERMIT_BIT]
                    && permit_armed_reg && (state_reg == ST_IDLE);
  assign go_erase = link.ctl_we && link.ctl_wdata[CTL_CLRGO_BIT] && ctl_reg[CTL_CLRALW_BIT]
                    && clrallow_armed_reg && (state_reg == ST_IDLE);
  assign cyc_end  = (state_reg == ST_DONE);
  assign permit_fall = permit_prev_reg && !ctl_reg[CTL_PERMIT_BIT];

  // Slow timer tick standing in for the independent internal oscillator.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tick_div_reg <= 16'h0000;
      tick_reg     <= 1'b0;
    end else if (tick_div_reg == 16'(DIV_LEN - 1)) begin
      tick_div_reg <= 16'h0000;
      tick_reg     <= 1'b1;
    end else begin
      tick_div_reg <= tick_div_reg + 16'h0001;
      tick_reg     <= 1'b0;
    end
  end

  always_comb begin
    ctl_next = ctl_reg;
    if (link.ctl_we && state_reg == ST_IDLE) begin
      ctl_next = link.ctl_wdata;
      ctl_next[CTL_GO_BIT]    = go_write;
      ctl_next[CTL_CLRGO_BIT] = go_erase;
    end
    if (cyc_end) begin
      ctl_next[CTL_GO_BIT]     = 1'b0;
      ctl_next[CTL_PERMIT_BIT] = 1'b0;
      if (is_erase_reg) begin
        ctl_next[CTL_CLRGO_BIT]  = 1'b0;
        ctl_next[CTL_CLRALW_BIT] = 1'b0;
      end
    end
  end

  // Control register; permit is clear out of reset.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctl_reg            <= CTL_RESET;
      permit_prev_reg    <= 1'b0;
      permit_armed_reg   <= 1'b0;
      clrallow_armed_reg <= 1'b0;
    end else begin
      ctl_reg            <= ctl_next;
      permit_prev_reg    <= ctl_reg[CTL_PERMIT_BIT];
      // Armed for exactly one following clock cycle after a set of the enable.
      permit_armed_reg   <= link.ctl_we && link.ctl_wdata[CTL_PERMIT_BIT]
                            && !ctl_reg[CTL_PERMIT_BIT];
      clrallow_armed_reg <= link.ctl_we && link.ctl_wdata[CTL_CLRALW_BIT]
                            && !ctl_reg[CTL_CLRALW_BIT];
    end
  end

  // Location register; page bits are never stepped by hardware.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      loc_reg <= 9'h000;
    end else if (link.loc_we && state_reg == ST_IDLE) begin
      loc_reg <= link.loc_wdata;
    end else if (link.byte_we && ctl_reg[CTL_MODE_BIT] && state_reg == ST_IDLE
                 && loc_reg[OFS_W-1:0] != OFS_LAST) begin
      loc_reg[OFS_W-1:0] <= loc_reg[OFS_W-1:0] + 4'h1;
    end
  end

  // Page buffer with per-entry tags telling which offsets take part.
  genvar gi;
  generate
    for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_buf
      always_ff @(posedge clock_i) begin
        if (!rst_n_i || permit_fall) begin
          buf_reg[gi] <= 8'h00;
          tag_reg[gi] <= 1'b0;
        end else if (link.byte_we && ctl_reg[CTL_MODE_BIT] && state_reg == ST_IDLE
                     && loc_reg[OFS_W-1:0] == 4'(gi)
                     && (4'(gi) != OFS_LAST || !tag_reg[gi])) begin
          // Only the boundary entry refuses a reload; lower offsets follow a new location.
          buf_reg[gi] <= link.byte_wdata;
          tag_reg[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      byte_reg <= 8'h00;
    end else if (link.byte_we && state_reg == ST_IDLE) begin
      byte_reg <= link.byte_wdata;
    end
  end

  // Cycle sequencer: erase phase, programming phase or erase then programming, each timed in ticks.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg     <= ST_IDLE;
      cyc_cnt_reg   <= 16'h0000;
      is_erase_reg  <= 1'b0;
      page_mode_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          cyc_cnt_reg <= 16'h0000;
          if (go_write) begin
            is_erase_reg  <= 1'b0;
            page_mode_reg <= ctl_reg[CTL_MODE_BIT];
            state_reg     <= ctl_reg[CTL_MODE_BIT] ? ST_PROG : ST_ERASE;
          end else if (go_erase) begin
            is_erase_reg  <= 1'b1;
            page_mode_reg <= 1'b1;
            state_reg     <= ST_ERASE;
          end
        end
        ST_ERASE, ST_PROG: begin
          if (tick_reg) begin
            // A page sweep may outlast a short timer, so the cycle waits for it to finish.
            if (cyc_cnt_reg == 16'(CYCLE_LEN - 1)) begin
              if (!page_mode_reg || wr_idx_reg == 5'(PAGE_BYTES)) begin
                cyc_cnt_reg <= 16'h0000;
                state_reg   <= (state_reg == ST_ERASE && !is_erase_reg) ? ST_PROG : ST_DONE;
              end
            end else begin
              cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
            end
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Array strobes: a sweep over the tagged page entries or the single addressed byte.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      array_we_reg    <= 1'b0;
      array_addr_reg  <= 9'h000;
      array_wdata_reg <= 8'h00;
      wr_idx_reg      <= 5'h00;
    end else begin
      array_we_reg <= 1'b0;
      if (state_reg == ST_IDLE) begin
        wr_idx_reg <= 5'h00;
      end else if (state_reg == ST_ERASE && !is_erase_reg) begin
        array_we_reg    <= (cyc_cnt_reg == 16'h0000) && tick_reg;
        array_addr_reg  <= loc_reg;
        array_wdata_reg <= 8'h00;
      end else if ((state_reg == ST_PROG || state_reg == ST_ERASE) && page_mode_reg) begin
        // The index stops one past the last entry, so no entry is strobed twice.
        if (wr_idx_reg != 5'(PAGE_BYTES)) begin
          array_we_reg    <= tag_reg[wr_idx_reg[OFS_W-1:0]];
          array_addr_reg  <= {loc_reg[ADDR_W-1:OFS_W], wr_idx_reg[OFS_W-1:0]};
          array_wdata_reg <= is_erase_reg ? 8'h00 : buf_reg[wr_idx_reg[OFS_W-1:0]];
          wr_idx_reg      <= wr_idx_reg + 5'h01;
        end
      end else if (state_reg == ST_PROG && cyc_cnt_reg == 16'h0000 && tick_reg) begin
        array_we_reg    <= 1'b1;
        array_addr_reg  <= loc_reg;
        array_wdata_reg <= byte_reg;
      end
    end
  end

  // Busy is registered from the start request and the current state, so it stays high through ST_DONE and the output comes from a flip-flop.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= go_write || go_erase || (state_reg == ST_ERASE) || (state_reg == ST_PROG);
    end
  end

  // Interrupt flag; a new cycle end wins over a same-cycle service clear.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_reg <= 1'b0;
    end else if (cyc_end) begin
      irq_reg <= 1'b1;
    end else if (link.irq_service) begin
      irq_reg <= 1'b0;
    end
  end

  assign link.ctl_rdata = ctl_reg;
  assign link.loc_rdata = loc_reg;
  assign link.irq_flag  = irq_reg && link.irq_allow;
  assign array_we_o     = array_we_reg;
  assign array_addr_o   = array_addr_reg;
  assign array_wdata_o  = array_wdata_reg;
  assign busy_o         = busy_reg;

endmodule
`default_nettype wire

// ==== hw/nv_core_side.sv ====
// Software-side end: APB registers that drive the activation sequences to the controller.
`timescale 1ns/10ps
`default_nettype none
module nv_core_side (
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Link to controller.
  nv_link_if.core          link,
  // Interrupt request toward the core.
  output logic             irq_o
);
  import nv_write_pkg::*;

  typedef enum logic [2:0] {
    SQ_IDLE   = 3'b000,
    SQ_ENABLE = 3'b001,
    SQ_GO     = 3'b010,
    SQ_WAIT   = 3'b011,
    SQ_SVC    = 3'b100
  } seq_e;

  seq_e        seq_reg;
  logic        ctl_we_reg;
  logic [7:0]  ctl_wdata_reg;
  logic        loc_we_reg;
  logic [8:0]  loc_wdata_reg;
  logic        byte_we_reg;
  logic [7:0]  byte_wdata_reg;
  logic        erase_reg;
  logic        mode_reg;
  logic        svc_reg;
  logic        gate_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        irq_reg;
  logic        wr_acc;
  logic        busy;

  assign wr_acc = psel_i && penable_i && pwrite_i && pready_reg;
  assign busy   = (seq_reg != SQ_IDLE);

  // APB answer: one wait state, then pready for one cycle.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= psel_i && penable_i && !pready_reg;
      pslverr_reg <= 1'b0;
      if (psel_i && penable_i && !pready_reg) begin
        if (paddr_i == OFS_STATUS) begin
          prdata_reg <= {21'h0, gate_reg, link.irq_flag, busy, link.ctl_rdata};
        end else if (paddr_i == OFS_ADDR) begin
          prdata_reg <= {23'h0, link.loc_rdata};
        end else if (paddr_i == OFS_CMD || paddr_i == OFS_DATA) begin
          prdata_reg <= 32'h0000_0000;
        end else begin
          prdata_reg  <= 32'h0000_0000;
          pslverr_reg <= 1'b1;
        end
      end
    end
  end

  // Command sequencer: enable then go on the very next link write, gate closed meanwhile.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      seq_reg        <= SQ_IDLE;
      ctl_we_reg     <= 1'b0;
      ctl_wdata_reg  <= CTL_RESET;
      loc_we_reg     <= 1'b0;
      loc_wdata_reg  <= 9'h000;
      byte_we_reg    <= 1'b0;
      byte_wdata_reg <= 8'h00;
      erase_reg      <= 1'b0;
      mode_reg       <= 1'b0;
      svc_reg        <= 1'b0;
      gate_reg       <= 1'b1;
    end else begin
      ctl_we_reg  <= 1'b0;
      loc_we_reg  <= 1'b0;
      byte_we_reg <= 1'b0;
      svc_reg     <= 1'b0;
      case (seq_reg)
        SQ_IDLE: begin
          if (wr_acc && paddr_i == OFS_ADDR) begin
            loc_we_reg    <= 1'b1;
            loc_wdata_reg <= pwdata_i[8:0];
            // Bit 9 picks the mode first, so that later data writes fill the page buffer.
            ctl_we_reg    <= 1'b1;
            ctl_wdata_reg <= {3'h0, pwdata_i[9], 4'h0};
          end else if (wr_acc && paddr_i == OFS_DATA) begin
            byte_we_reg    <= 1'b1;
            byte_wdata_reg <= pwdata_i[7:0];
          end else if (wr_acc && paddr_i == OFS_CMD) begin
            if (pwdata_i[2:0] == CMD_SERVICE) begin
              svc_reg <= 1'b1;
            end else if (pwdata_i[2:0] != 3'h0) begin
              erase_reg <= (pwdata_i[2:0] == CMD_PAGE_ERASE);
              mode_reg  <= (pwdata_i[2:0] != CMD_BYTE_WRITE);
              gate_reg  <= 1'b0;
              ctl_we_reg    <= 1'b1;
              ctl_wdata_reg <= 8'h00 | {3'h0, (pwdata_i[2:0] != CMD_BYTE_WRITE), 4'h0};
              seq_reg   <= SQ_ENABLE;
            end
          end
        end
        SQ_ENABLE: begin
          ctl_we_reg    <= 1'b1;
          ctl_wdata_reg <= {1'b0, erase_reg, 1'b0, mode_reg, 4'h0}
                           | (erase_reg ? 8'h40 : 8'h08);
          seq_reg       <= SQ_GO;
        end
        SQ_GO: begin
          ctl_we_reg    <= 1'b1;
          ctl_wdata_reg <= {1'b0, erase_reg, erase_reg, mode_reg, !erase_reg,
                            !erase_reg, 2'b00};
          seq_reg       <= SQ_WAIT;
        end
        SQ_WAIT: begin
          gate_reg <= 1'b1;
          if (!link.ctl_rdata[CTL_GO_BIT] && !link.ctl_rdata[CTL_CLRGO_BIT] && !ctl_we_reg) begin
            seq_reg <= SQ_IDLE;
          end
        end
        default: begin
          seq_reg <= SQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= link.irq_flag && gate_reg;
    end
  end

  assign link.ctl_we      = ctl_we_reg;
  assign link.ctl_wdata   = ctl_wdata_reg;
  assign link.loc_we      = loc_we_reg;
  assign link.loc_wdata   = loc_wdata_reg;
  assign link.byte_we     = byte_we_reg;
  assign link.byte_wdata  = byte_wdata_reg;
  assign link.irq_allow   = 1'b1;
  assign link.irq_service = svc_reg;
  assign prdata_o         = prdata_reg;
  assign pready_o         = pready_reg;
  assign pslverr_o        = pslverr_reg;
  assign irq_o            = irq_reg;

endmodule
`default_nettype wire

// ==== test/nv_write_sva.sv ====
// Assertions on the link between the core-side registers and the write controller.
`timescale 1ns/10ps
`default_nettype none
module nv_write_sva
  import nv_write_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic       ctl_we,
  input wire logic [7:0] ctl_wdata,
  input wire logic [7:0] ctl_rdata,
  input wire logic       loc_we,
  input wire logic [8:0] loc_wdata,
  input wire logic       byte_we,
  input wire logic [7:0] byte_wdata,
  input wire logic       irq_allow,
  input wire logic       irq_flag,
  input wire logic       irq_service,
  input wire logic [8:0] loc_rdata
);
  // Generous bound so that a whole page cycle on the shortened timer fits.
  localparam int MAX_CYC = 400;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence permit_wr;
    ctl_we && ctl_wdata[CTL_PERMIT_BIT];
  endsequence
  sequence go_wr;
    ctl_we && ctl_wdata[CTL_GO_BIT];
  endsequence
  sequence data_wr;
    byte_we && !loc_we;
  endsequence
  chk_go_after_permit: assert property (permit_wr ##1 go_wr |=> ctl_rdata[CTL_GO_BIT])
    else $error("go not accepted after permit");
  chk_go_completes: assert property ($rose(ctl_rdata[CTL_GO_BIT]) |-> ##[1:MAX_CYC] !ctl_rdata[CTL_GO_BIT])
    else $error("go flag never cleared");
  chk_permit_drops: assert property ($fell(ctl_rdata[CTL_GO_BIT]) |-> !ctl_rdata[CTL_PERMIT_BIT])
    else $error("permit left set after cycle");
  chk_end_flag: assert property ($fell(ctl_rdata[CTL_GO_BIT]) && irq_allow |-> ##[0:2] irq_flag)
    else $error("no interrupt flag at cycle end");
  chk_erase_bits: assert property ($fell(ctl_rdata[CTL_CLRGO_BIT]) |-> !ctl_rdata[CTL_CLRALW_BIT])
    else $error("erase allow left set");
  chk_flag_gated: assert property (irq_flag |-> irq_allow)
    else $error("flag shown while not allowed");
  chk_service_clear: assert property (irq_service && !ctl_rdata[CTL_GO_BIT] && !ctl_rdata[CTL_CLRGO_BIT] |=> !irq_flag)
    else $error("service did not clear flag");
  chk_page_fixed: assert property (data_wr |=> $stable(loc_rdata[8:4]))
    else $error("page selector moved");
  chk_offset_stop: assert property (data_wr and loc_rdata[3:0] == OFS_LAST |=> $stable(loc_rdata))
    else $error("offset left the boundary");
  chk_offset_step: assert property (data_wr and ctl_rdata[CTL_MODE_BIT] && loc_rdata[3:0] != OFS_LAST
      |=> loc_rdata[3:0] == $past(loc_rdata[3:0]) + 4'h1)
    else $error("offset did not step");
  chk_reset_state: assert property ($rose(rst_n_i) |-> ctl_rdata == CTL_RESET)
    else $error("control not clear after reset");
endmodule
`default_nettype wire

// ==== test/tb_nv_write_ctrl.sv ====
// Self-checking bench for the write controller, its APB core side and a directly driven spare.
`timescale 1ns/10ps
`default_nettype none
module tb_nv_write_ctrl;
  import nv_write_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic        rd_chk;
    logic [31:0] rd_exp;
    logic        err_exp;
  } row_s;
  logic        clock_i   = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        irq_o;
  logic        we_a;
  logic        busy_a;
  logic        we_b;
  logic        busy_b;
  logic [8:0]  addr_a;
  logic [8:0]  addr_b;
  logic [7:0]  wdata_a;
  logic [7:0]  wdata_b;
  logic [16:0] strobes[$];
  logic        seen_aa   = 1'b0;
  logic [31:0] rd;
  logic        er;
  int          err_count = 0;
  int          checks    = 0;
  row_s        rows[5]   = '{
    '{1'b0, OFS_STATUS, 32'h0, 1'b1, 32'h0000_0400, 1'b0},
    '{1'b1, OFS_ADDR, 32'h1a3, 1'b0, 32'h0, 1'b0},
    '{1'b1, OFS_DATA, 32'h5c, 1'b0, 32'h0, 1'b0},
    '{1'b0, 8'h10, 32'h0, 1'b0, 32'h0, 1'b1},
    '{1'b1, 8'h14, 32'h1, 1'b0, 32'h0, 1'b1}};
  nv_link_if link_a ();
  nv_link_if link_b ();
  nv_core_side nv_core_side_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .link(link_a), .irq_o(irq_o));
  nv_write_ctrl #(.CYCLE_LEN(2), .DIV_LEN(1)) nv_write_ctrl_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .link(link_a), .array_we_o(we_a),
    .array_addr_o(addr_a), .array_wdata_o(wdata_a), .busy_o(busy_a));
  // The spare end lets the bench break the activation order, which the core side never does.
  nv_write_ctrl #(.CYCLE_LEN(2), .DIV_LEN(1)) nv_write_ctrl_inst_b (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .link(link_b), .array_we_o(we_b),
    .array_addr_o(addr_b), .array_wdata_o(wdata_b), .busy_o(busy_b));
  nv_write_sva nv_write_sva_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ctl_we(link_a.ctl_we), .ctl_wdata(link_a.ctl_wdata),
    .ctl_rdata(link_a.ctl_rdata), .loc_we(link_a.loc_we), .loc_wdata(link_a.loc_wdata),
    .byte_we(link_a.byte_we), .byte_wdata(link_a.byte_wdata), .irq_allow(link_a.irq_allow),
    .irq_flag(link_a.irq_flag), .irq_service(link_a.irq_service),
    .loc_rdata(link_a.loc_rdata));
  initial begin
    forever #4 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (we_a === 1'b1) begin
      strobes.push_back({addr_a, wdata_a});
    end
    if (we_b === 1'b1 && wdata_b === 8'haa) begin
      seen_aa <= 1'b1;
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // One idle edge keeps the next call from assigning psel in the same time step.
    @(posedge clock_i);
  endtask
  // Polls status until the busy bit drops; only the watchdog ends a hung wait.
  task automatic run_cmd(input logic [2:0] c);
    apb(1'b1, OFS_CMD, {29'h0, c});
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
    end while (rd[8] !== 1'b0);
  endtask
  // Kind 0 control, 1 location, 2 data byte, 3 idle; strobes stay up across back-to-back calls.
  task automatic drive_b(input logic [1:0] k, input logic [8:0] v);
    link_b.ctl_we <= (k == 2'd0);
    link_b.loc_we <= (k == 2'd1);
    link_b.byte_we <= (k == 2'd2);
    link_b.ctl_wdata <= v[7:0];
    link_b.loc_wdata <= v;
    link_b.byte_wdata <= v[7:0];
    @(posedge clock_i);
  endtask
  task automatic summarize();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    summarize();
  end
  initial begin
    link_b.ctl_we = 1'b0;
    link_b.loc_we = 1'b0;
    link_b.byte_we = 1'b0;
    link_b.ctl_wdata = 8'h00;
    link_b.loc_wdata = 9'h000;
    link_b.byte_wdata = 8'h00;
    link_b.irq_allow = 1'b0;
    link_b.irq_service = 1'b0;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      check("pslverr", {31'h0, er}, {31'h0, rows[i].err_exp});
      if (rows[i].rd_chk) check("prdata", rd, rows[i].rd_exp);
    end
    strobes.delete();
    run_cmd(CMD_BYTE_WRITE);
    check("byte strobes", strobes.size(), 2);
    check("erase strobe", {15'h0, strobes[0]}, {15'h0, 9'h1a3, 8'h00});
    check("program strobe", {15'h0, strobes[1]}, {15'h0, 9'h1a3, 8'h5c});
    check("go and permit", {24'h0, rd[7:0] & 8'h0c}, 32'h0);
    check("irq pending", {31'h0, rd[9]}, 32'h1);
    check("irq line", {31'h0, irq_o}, 32'h1);
    apb(1'b1, OFS_CMD, {29'h0, CMD_SERVICE});
    apb(1'b0, OFS_STATUS, 32'h0);
    check("irq serviced", {31'h0, rd[9]}, 32'h0);
    check("irq line low", {31'h0, irq_o}, 32'h0);
    // Address bit 9 selects page mode, so the data writes below tag the buffer.
    apb(1'b1, OFS_ADDR, 32'h2a0);
    for (int i = 0; i < 4; i++) apb(1'b1, OFS_DATA, 32'h77);
    strobes.delete();
    run_cmd(CMD_PAGE_ERASE);
    check("erase bits", {30'h0, rd[6:5]}, 32'h0);
    check("erase seen", {31'h0, strobes.size() > 0}, 32'h1);
    foreach (strobes[i]) check("erase data", {strobes[i][16:12], strobes[i][7:0]}, {5'h0a, 8'h00});
    apb(1'b1, OFS_ADDR, 32'h2a0);
    for (int i = 0; i < 17; i++) apb(1'b1, OFS_DATA, 32'h10 + i);
    strobes.delete();
    run_cmd(CMD_PAGE_WRITE);
    check("page count", strobes.size(), PAGE_BYTES);
    foreach (strobes[i]) check("page strobe", strobes[i], {9'h0a0 + 9'(i), 8'h10 + 8'(i)});
    drive_b(2'd0, 9'h004);
    drive_b(2'd3, 9'h0);
    repeat (10) @(posedge clock_i);
    check("lone go", {busy_b, link_b.ctl_rdata[CTL_GO_BIT]}, 32'h0);
    drive_b(2'd0, 9'h008);
    drive_b(2'd3, 9'h0);
    drive_b(2'd0, 9'h00c);
    drive_b(2'd3, 9'h0);
    repeat (10) @(posedge clock_i);
    check("late go", {busy_b, link_b.ctl_rdata[CTL_GO_BIT]}, 32'h0);
    drive_b(2'd0, 9'h010);
    drive_b(2'd1, 9'h1fe);
    drive_b(2'd2, 9'h011);
    drive_b(2'd2, 9'h022);
    drive_b(2'd2, 9'h033);
    drive_b(2'd3, 9'h0);
    check("saturated loc", {23'h0, link_b.loc_rdata}, 32'h1ff);
    drive_b(2'd0, 9'h018);
    drive_b(2'd1, 9'h040);
    drive_b(2'd2, 9'h0aa);
    drive_b(2'd0, 9'h010);
    drive_b(2'd0, 9'h018);
    drive_b(2'd0, 9'h01c);
    drive_b(2'd3, 9'h0);
    while (busy_b !== 1'b0) @(posedge clock_i);
    repeat (4) @(posedge clock_i);
    check("cleared buffer", {31'h0, seen_aa}, 32'h0);
    check("spare go and permit", {24'h0, link_b.ctl_rdata & 8'h0c}, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
